//--- src/stream_write_defines.vh
// constants for the streaming sector-write command interpreter
// included by every design file but the interrupt block; definitions only
`ifndef STREAM_WRITE_DEFINES_VH
`define STREAM_WRITE_DEFINES_VH

// register offsets on the plain register port (4-bit address)
`define OFS_DATA          4'h0
`define OFS_FEATURE       4'h1
`define OFS_COUNT         4'h2
`define OFS_LBA_LOW       4'h3
`define OFS_LBA_MID       4'h4
`define OFS_LBA_HIGH      4'h5
`define OFS_DEVICE        4'h6
`define OFS_COMMAND       4'h7
`define OFS_DEV_CONTROL   4'h8
`define OFS_TIME_LIMIT    4'h9
`define OFS_IRQ_STATUS    4'hA
`define OFS_IRQ_CLEAR     4'hB
`define OFS_IRQ_ENABLE    4'hC

// command code
`define CMD_STREAM_WRITE  8'h3B

// feature bits
`define FEAT_URGENT       7
`define FEAT_CONTINUE     6
`define FEAT_FLUSH        5

// error bits
`define ERR_CRC           7
`define ERR_ID_NOT_FOUND  4
`define ERR_ABORTED       2
`define ERR_TIME_LIMIT    0
`define ERR_MASK          8'h95

// status bits
`define ST_BUSY           7
`define ST_READY          6
`define ST_STREAM_ERR     5
`define ST_DRQ            3
`define ST_ERR            0

// device control bit selecting the upper address bytes
`define CTL_HOB           7

// interrupt status bits
`define IRQ_DONE          0
`define IRQ_TIMEOUT       1
`define IRQ_ERROR         2

// time limit unit in us and cycles per us at 100 MHz
`define TIME_UNIT_US      1
`define CLK_MHZ           100
`define TICK_CYCLES       (`TIME_UNIT_US * `CLK_MHZ)

`endif

//--- src/limit_timer.v
// completion time limit counter in microsecond ticks
// assumes start is a one-cycle pulse; limit of zero means no limit
`timescale 1ns/1ps
`include "stream_write_defines.vh"
module limit_timer (
  input wire ref_clk,
  input wire reset,
  input wire start,
  input wire stop,
  input wire [15:0] limitUs,
  output reg expired_q
);
  reg [6:0] tick_q;
  reg [15:0] left_q;
  reg run_q;

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      tick_q <= 7'h00;
      left_q <= 16'h0000;
      run_q <= 1'b0;
      expired_q <= 1'b0;
    end
    else if (start)
    begin
      tick_q <= 7'h00;
      left_q <= limitUs;
      run_q <= (limitUs != 16'h0000);
      expired_q <= 1'b0;
    end
    else if (stop)
      run_q <= 1'b0;
    else if (run_q)
    begin
      if ({25'h0, tick_q} == `TICK_CYCLES - 1)
      begin
        tick_q <= 7'h00;
        if (left_q == 16'h0001)
        begin
          run_q <= 1'b0;
          expired_q <= 1'b1;
        end
        left_q <= left_q - 16'h0001;
      end
      else
        tick_q <= tick_q + 7'h01;
    end
  end
endmodule // limit_timer

//--- src/irq_block.v
// sticky event bits, write-one clear, enable mask, level interrupt
// assumes events are one-cycle pulses from the same clock
`timescale 1ns/1ps
module irq_block (
  input wire ref_clk,
  input wire reset,
  input wire [2:0] events,
  input wire clearWr,
  input wire enableWr,
  input wire [2:0] wrData,
  output reg [2:0] status_q,
  output reg [2:0] enable_q,
  output wire irq
);
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      status_q <= 3'h0;
      enable_q <= 3'h0;
    end
    else
    begin
      // a new event wins over a clear in the same cycle
      status_q <= (status_q & ~(clearWr ? wrData : 3'h0)) | events;
      if (enableWr)
        enable_q <= wrData;
    end
  end

  assign irq = |(status_q & enable_q);
endmodule // irq_block

//--- src/stream_write_cmd.v
// streaming sector-write command interpreter, device side
// assumes a same-clock register port and a media engine handshake
//
// Operation
// R1: a write of 3Bh to the command register starts the stream write.
// R2: a sector count of zero means 65536 sectors, else 1 to 65535.
// R3: in continue-on-error mode transfer or media errors never abort.
// R4: continue mode with errors moves all data, ends with stream error set.
// R5: continue mode with time limit expiry halts and reports the expiry; the code ignores an expiry that falls in the flush.
// R6: the device always tries to move all the data within the limit; the code stops at the first sector error when continue mode is off.
// R7: feature bit 7 marks an urgent request passed to the media engine.
// R8: feature bit 6 set by the host selects continue-on-error mode.
// R9: feature bit 5 flushes the stream to the media before completion.
// R10: the error register carries only crc, no-id, aborted, expiry bits.
// R11: at completion busy, deferred error and corrected read zero.
// R12: the first failing 48-bit address is returned, split by high byte.
// R13: the host writes the count high byte then the low byte.
// R14: error bit 0 is set whenever the time limit is overrun; the code leaves it clear when the expiry falls in the flush.
`timescale 1ns/1ps
`include "stream_write_defines.vh"
module stream_write_cmd (
  input wire ref_clk,
  input wire reset,
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdData_q,
  output reg [15:0] wordData_q,
  output reg wordValid_q,
  output reg urgent_q,
  output reg flushReq_q,
  input wire flushDone,
  input wire sectorDone,
  input wire sectorNoId,
  input wire sectorCrc,
  output wire irq
);
  localparam S_IDLE = 5'h01;
  localparam S_DATA = 5'h02;
  localparam S_FLUSH = 5'h04;
  localparam S_DONE = 5'h08;
  localparam S_FAIL = 5'h10;

  reg [4:0] state_q;
  reg [7:0] feature_q;
  reg [7:0] featurePrev_q;
  reg [7:0] countCur_q;
  reg [7:0] countPrev_q;
  reg [7:0] lbaCur_q [0:2];
  reg [7:0] lbaPrev_q [0:2];
  reg [7:0] device_q;
  reg hob_q;
  reg [16:0] sectorsLeft_q;
  reg [47:0] curLba_q;
  reg [47:0] failLba_q;
  reg failSeen_q;
  reg [7:0] error_q;
  reg streamErr_q;
  reg errFlag_q;
  reg [15:0] timeLimit_q;
  reg continue_q;
  reg [2:0] events;
  wire expired;
  wire [2:0] irqStatus;
  wire [2:0] irqEnable;
  wire busy;
  wire wrEv;
  wire sectorErr;
  wire irqClearWr;
  wire irqEnableWr;
  integer i;

  // pick the byte of a 48-bit address for a given register slot
  function [7:0] lbaByte;
    input [47:0] lba;
    input [1:0] slot;
    input hob;
    begin
      case ({hob, slot})
        3'b000: lbaByte = lba[7:0];
        3'b001: lbaByte = lba[15:8];
        3'b010: lbaByte = lba[23:16];
        3'b100: lbaByte = lba[31:24];
        3'b101: lbaByte = lba[39:32];
        3'b110: lbaByte = lba[47:40];
        default: lbaByte = 8'h00;
      endcase
    end
  endfunction

  function isWr;
    input [3:0] ofs;
    begin
      isWr = regWr && (regAddr == ofs);
    end
  endfunction

  assign busy = (state_q == S_DATA) || (state_q == S_FLUSH);
  // nets decode the strobe directly: a function here would miss its inputs
  assign wrEv = regWr && (regAddr == `OFS_COMMAND);
  assign irqClearWr = regWr && (regAddr == `OFS_IRQ_CLEAR);
  assign irqEnableWr = regWr && (regAddr == `OFS_IRQ_ENABLE);
  assign sectorErr = sectorNoId || sectorCrc;

  ////////////////////////////////////////////////////////////////////////
  // parameter registers, two-deep slots for the 48-bit forms

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      feature_q <= 8'h00;
      featurePrev_q <= 8'h00;
      countCur_q <= 8'h00;
      countPrev_q <= 8'h00;
      device_q <= 8'h00;
      hob_q <= 1'b0;
      timeLimit_q <= 16'h0000;
      for (i = 0; i < 3; i = i + 1)
      begin
        lbaCur_q[i] <= 8'h00;
        lbaPrev_q[i] <= 8'h00;
      end
    end
    else if (!busy)
    begin
      if (isWr(`OFS_FEATURE))
      begin
        featurePrev_q <= feature_q;
        feature_q <= regWrData[7:0];
      end
      if (isWr(`OFS_COUNT))
      begin
        countPrev_q <= countCur_q; // R13
        countCur_q <= regWrData[7:0];
      end
      for (i = 0; i < 3; i = i + 1)
        if (isWr(`OFS_LBA_LOW + i[3:0]))
        begin
          lbaPrev_q[i] <= lbaCur_q[i];
          lbaCur_q[i] <= regWrData[7:0];
        end
      if (isWr(`OFS_DEVICE))
        device_q <= regWrData[7:0];
      if (isWr(`OFS_DEV_CONTROL))
        hob_q <= regWrData[`CTL_HOB];
      if (isWr(`OFS_TIME_LIMIT))
        timeLimit_q <= regWrData;
    end
    // the byte select stays writable while busy
    else if (isWr(`OFS_DEV_CONTROL))
      hob_q <= regWrData[`CTL_HOB];
  end

  ////////////////////////////////////////////////////////////////////////
  // command state machine

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_q <= S_IDLE;
      sectorsLeft_q <= 17'h00000;
      curLba_q <= 48'h000000000000;
      failLba_q <= 48'h000000000000;
      failSeen_q <= 1'b0;
      error_q <= 8'h00;
      streamErr_q <= 1'b0;
      errFlag_q <= 1'b0;
      continue_q <= 1'b0;
      urgent_q <= 1'b0;
      flushReq_q <= 1'b0;
      wordData_q <= 16'h0000;
      wordValid_q <= 1'b0;
      events <= 3'h0;
    end
    else
    begin
      wordValid_q <= 1'b0;
      events <= 3'h0;
      case (state_q)
        S_IDLE:
        begin
          if (wrEv && regWrData[7:0] == `CMD_STREAM_WRITE) // R1
          begin
            state_q <= S_DATA;
            sectorsLeft_q <= ({countPrev_q, countCur_q} == 16'h0000) ?
              17'h10000 : {1'b0, countPrev_q, countCur_q}; // R2
            curLba_q <= {lbaPrev_q[2], lbaPrev_q[1], lbaPrev_q[0],
              lbaCur_q[2], lbaCur_q[1], lbaCur_q[0]};
            continue_q <= feature_q[`FEAT_CONTINUE]; // R8
            urgent_q <= feature_q[`FEAT_URGENT]; // R7
            failSeen_q <= 1'b0;
            error_q <= 8'h00;
            streamErr_q <= 1'b0;
            errFlag_q <= 1'b0;
          end
          // any other code is refused with an abort
          else if (wrEv)
          begin
            error_q <= 8'h00 | (8'h01 << `ERR_ABORTED);
            errFlag_q <= 1'b1;
            events <= 3'h1 << `IRQ_ERROR;
          end
        end
        S_DATA:
        begin
          if (isWr(`OFS_DATA))
          begin
            wordData_q <= regWrData;
            wordValid_q <= 1'b1;
          end
          // in continue mode expiry wins over a sector ending in the same cycle
          if (expired && continue_q) // R5
          begin
            error_q[`ERR_TIME_LIMIT] <= 1'b1; // R14
            streamErr_q <= 1'b1;
            errFlag_q <= 1'b0;
            state_q <= S_FAIL;
            events <= 3'h1 << `IRQ_TIMEOUT;
          end
          else if (sectorDone)
          begin
            if (sectorErr)
            begin
              if (!failSeen_q)
              begin
                failSeen_q <= 1'b1;
                failLba_q <= curLba_q; // R12
              end
              if (sectorNoId)
                error_q[`ERR_ID_NOT_FOUND] <= 1'b1;
              if (sectorCrc)
                error_q[`ERR_CRC] <= 1'b1;
              if (continue_q)
                streamErr_q <= 1'b1; // R4
            end
            if (sectorErr && !continue_q)
            begin
              errFlag_q <= 1'b1;
              state_q <= S_FAIL;
              events <= 3'h1 << `IRQ_ERROR;
            end
            else if (sectorsLeft_q == 17'h00001) // R3 R6
            begin
              flushReq_q <= feature_q[`FEAT_FLUSH];
              state_q <= feature_q[`FEAT_FLUSH] ? S_FLUSH : S_DONE;
              if (!feature_q[`FEAT_FLUSH])
                events <= 3'h1 << `IRQ_DONE;
            end
            sectorsLeft_q <= sectorsLeft_q - 17'h00001;
            curLba_q <= curLba_q + 48'h000000000001;
          end
          else if (expired)
          begin
            error_q[`ERR_TIME_LIMIT] <= 1'b1; // R14
            errFlag_q <= 1'b1;
            state_q <= S_FAIL;
            events <= 3'h1 << `IRQ_TIMEOUT;
          end
        end
        S_FLUSH:
        begin
          if (flushDone) // R9
          begin
            flushReq_q <= 1'b0;
            state_q <= S_DONE;
            events <= 3'h1 << `IRQ_DONE;
          end
        end
        S_DONE, S_FAIL:
        begin
          urgent_q <= 1'b0;
          flushReq_q <= 1'b0;
          state_q <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time limit and interrupts

  // refused codes start it too; the stop input parks it at once
  limit_timer uTimer (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(wrEv && state_q == S_IDLE),
    .stop(!busy),
    .limitUs(timeLimit_q),
    .expired_q(expired)
  );

  irq_block uIrq (
    .ref_clk(ref_clk),
    .reset(reset),
    .events(events),
    .clearWr(irqClearWr),
    .enableWr(irqEnableWr),
    .wrData(regWrData[2:0]),
    .status_q(irqStatus),
    .enable_q(irqEnable),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // read port, data valid one cycle after the strobe

  always @(posedge ref_clk)
  begin
    if (reset)
      regRdData_q <= 16'h0000;
    else if (regRd)
    begin
      case (regAddr)
        `OFS_FEATURE:
          regRdData_q <= {8'h00, error_q &
            `ERR_MASK}; // R10
        // indices 3 to 5 map to slots 0 to 2
        `OFS_LBA_LOW, `OFS_LBA_MID, `OFS_LBA_HIGH:
          regRdData_q <= {8'h00, lbaByte(failLba_q,
            regAddr[1:0] - 2'h3, hob_q)}; // R12
        `OFS_DEVICE:
          regRdData_q <= {8'h00, device_q};
        `OFS_COMMAND:
          regRdData_q <= {8'h00, busy, !busy, streamErr_q, 1'b0,
            state_q == S_DATA, 1'b0, 1'b0, errFlag_q}; // R11
        `OFS_TIME_LIMIT:
          regRdData_q <= timeLimit_q;
        `OFS_IRQ_STATUS:
          regRdData_q <= {13'h0000, irqStatus};
        `OFS_IRQ_ENABLE:
          regRdData_q <= {13'h0000, irqEnable};
        default:
          regRdData_q <= 16'h0000;
      endcase
    end
    else
      regRdData_q <= 16'h0000;
  end
endmodule // stream_write_cmd

//--- verif/stream_write_assertions.sv
// concurrent checks on the stream write command interpreter ports
// assumes the register indices and bit positions of the defines header
`timescale 1ns/1ps
`include "stream_write_defines.vh"
module stream_write_checker (
  input wire ref_clk,
  input wire reset,
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [15:0] regRdData_q,
  input wire [15:0] wordData_q,
  input wire wordValid_q,
  input wire urgent_q,
  input wire flushReq_q,
  input wire flushDone,
  input wire irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  property p_cmd_busy;
    regWr && regAddr == `OFS_COMMAND && regWrData[7:0] == `CMD_STREAM_WRITE
    ##2 regRd && regAddr == `OFS_COMMAND |=> regRdData_q[`ST_BUSY];
  endproperty
  a_cmd_busy: assert property (p_cmd_busy)
    else $error("status not busy after command write");
  property p_rd_idle;
    !$past(regRd) |-> regRdData_q == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read answer cycle");
  property p_word_src;
    wordValid_q |-> $past(regWr && regAddr == `OFS_DATA);
  endproperty
  a_word_src: assert property (p_word_src)
    else $error("data word without data write");
  property p_word_val;
    wordValid_q |-> wordData_q == $past(regWrData);
  endproperty
  a_word_val: assert property (p_word_val)
    else $error("data word differs from written data");
  property p_flush_hold;
    flushReq_q && !flushDone |=> flushReq_q;
  endproperty
  a_flush_hold: assert property (p_flush_hold)
    else $error("flush request dropped before flush done");
  property p_flush_end;
    $fell(flushReq_q) |-> $past(flushDone);
  endproperty
  a_flush_end: assert property (p_flush_end)
    else $error("flush request fell without flush done");
  property p_stat_zero;
    $past(regRd && regAddr == `OFS_COMMAND) |->
      !regRdData_q[4] && !regRdData_q[2];
  endproperty
  a_stat_zero: assert property (p_stat_zero)
    else $error("deferred or corrected status bit set");
  property p_err_zero;
    $past(regRd && regAddr == `OFS_FEATURE) |->
      regRdData_q[6:5] == 2'b00 && !regRdData_q[3] && !regRdData_q[1];
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("reserved error bit set");
  property p_urg_stable;
    wordValid_q |-> $stable(urgent_q);
  endproperty
  a_urg_stable: assert property (p_urg_stable)
    else $error("urgent level changed during data");
  property p_irq_off;
    regWr && regAddr == `OFS_IRQ_ENABLE && regWrData[2:0] == 3'h0 |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt high with all enables clear");
endmodule // stream_write_checker
bind stream_write_cmd stream_write_checker u_checker (.ref_clk(ref_clk),
  .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData_q(regRdData_q), .wordData_q(wordData_q),
  .wordValid_q(wordValid_q), .urgent_q(urgent_q), .flushReq_q(flushReq_q),
  .flushDone(flushDone), .irq(irq));

//--- verif/media_model.sv
// media engine model: one sector per data word, flush answered late
// assumes errAt counts data words since reset
`timescale 1ns/1ps
module media_model (
  input wire ref_clk,
  input wire reset,
  input wire wordValid,
  input wire flushReq,
  input wire [15:0] errAt,
  input wire errCrc,
  output reg sectorDone,
  output reg sectorNoId,
  output reg sectorCrc,
  output reg flushDone
);
  reg [15:0] count_q;
  reg [1:0] pend_q;
  reg [1:0] bad_q;
  reg [2:0] wait_q;
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      count_q <= 16'h0000;
      pend_q <= 2'b00;
      bad_q <= 2'b00;
      wait_q <= 3'h0;
      sectorDone <= 1'b0;
      sectorNoId <= 1'b0;
      sectorCrc <= 1'b0;
      flushDone <= 1'b0;
    end
    else
    begin
      if (wordValid)
        count_q <= count_q + 16'h0001;
      pend_q <= {pend_q[0], wordValid};
      bad_q <= {bad_q[0], wordValid && count_q == errAt};
      sectorDone <= pend_q[1];
      sectorNoId <= bad_q[1] & ~errCrc;
      sectorCrc <= bad_q[1] & errCrc;
      // flush done only after a stall, never at once
      wait_q <= (flushReq && !flushDone) ? wait_q + 3'h1 : 3'h0;
      flushDone <= (wait_q == 3'h6);
    end
  end
endmodule // media_model

//--- verif/testbench.sv
// self-checking bench for the stream write command interpreter
// assumes byte registers in the low half of the 16-bit register port
`timescale 1ns/1ps
module testbench;
  reg ref_clk, reset, regWr, regRd, errCrc;
  reg [3:0] regAddr;
  reg [15:0] regWrData, rdv, errAt;
  reg [47:0] fl;
  wire [15:0] regRdData_q, wordData_q;
  wire wordValid_q, urgent_q, flushReq_q, flushDone, irq;
  wire sectorDone, sectorNoId, sectorCrc;
  integer n_mismatch, check_count, cycles, nWords, n0, i, j;
  stream_write_cmd u_stream_write_cmd (.ref_clk(ref_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData_q(regRdData_q), .wordData_q(wordData_q),
    .wordValid_q(wordValid_q), .urgent_q(urgent_q), .flushReq_q(flushReq_q),
    .flushDone(flushDone), .sectorDone(sectorDone), .sectorNoId(sectorNoId),
    .sectorCrc(sectorCrc), .irq(irq));
  media_model u_media_model (.ref_clk(ref_clk), .reset(reset),
    .wordValid(wordValid_q), .flushReq(flushReq_q), .errAt(errAt),
    .errCrc(errCrc), .sectorDone(sectorDone), .sectorNoId(sectorNoId),
    .sectorCrc(sectorCrc), .flushDone(flushDone));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task complete_run;
  begin
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [3:0] a, input [15:0] d);
  begin
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  end
  endtask
  task rd(input [3:0] a);
  begin
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    rdv = regRdData_q;
  end
  endtask
  task cmd(input [7:0] f, input [15:0] n, input [47:0] l, input [7:0] c);
    integer k;
  begin
    wr(4'h1, {8'h00, f});
    wr(4'h2, {8'h00, n[15:8]});
    wr(4'h2, {8'h00, n[7:0]});
    for (k = 0; k < 3; k = k + 1)
    begin
      wr(4'h3 + k[3:0], {8'h00, l[24 + 8 * k +: 8]});
      wr(4'h3 + k[3:0], {8'h00, l[8 * k +: 8]});
    end
    wr(4'h7, {8'h00, c});
  end
  endtask
  task words(input integer cnt);
    integer k;
  begin
    for (k = 0; k < cnt; k = k + 1)
      wr(4'h0, 16'hA500 + k[15:0]);
  end
  endtask
  task idle;
    integer k;
  begin
    k = 0;
    rd(4'h7);
    while (rdv[7] !== 1'b0 && k < 400)
    begin
      rd(4'h7);
      k = k + 1;
    end
  end
  endtask
  task stat(input [7:0] s, input [7:0] e);
  begin
    rd(4'h7);
    chk(rdv & 16'h00F5, {8'h00, s});
    rd(4'h1);
    chk(rdv, {8'h00, e});
  end
  endtask
  // the planned sequence needs about 1200 cycles
  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (wordValid_q === 1'b1)
      nWords = nWords + 1;
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
  end
  initial
  begin
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    nWords = 0;
    reset = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    errAt = 16'hFFFF;
    errCrc = 1'b0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    n0 = nWords;
    cmd(8'h00, 16'h0002, 48'h0, 8'h3B);
    rd(4'h7);
    chk(rdv & 16'h0080, 16'h0080);
    words(2);
    idle;
    stat(8'h40, 8'h00);
    chk(nWords - n0, 2);
    wr(4'h6, 16'h00E0);
    rd(4'h6);
    chk(rdv, 16'h00E0);
    rd(4'hA);
    chk(rdv & 16'h0001, 16'h0001);
    wr(4'hC, 16'h0001);
    #1 chk({15'h0, irq}, 16'h0001);
    wr(4'hB, 16'h0001);
    #1 chk({15'h0, irq}, 16'h0000);
    cmd(8'hA0, 16'h0001, 48'h0, 8'h3B);
    rd(4'h7);
    chk({15'h0, urgent_q}, 16'h0001);
    words(1);
    i = 0;
    while (flushReq_q !== 1'b1 && i < 50)
    begin
      @(posedge ref_clk);
      i = i + 1;
    end
    rd(4'h7);
    chk(rdv & 16'h0080, 16'h0080);
    idle;
    stat(8'h40, 8'h00);
    n0 = nWords;
    errAt = nWords + 1;
    fl = 48'h123456789ABD;
    cmd(8'h40, 16'h0003, 48'h123456789ABC, 8'h3B);
    words(3);
    idle;
    stat(8'h60, 8'h10);
    chk(nWords - n0, 3);
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(4'h8, i ? 16'h0080 : 16'h0000);
      for (j = 0; j < 3; j = j + 1)
      begin
        rd(4'h3 + j[3:0]);
        chk(rdv & 16'h00FF, {8'h00, fl[24 * i + 8 * j +: 8]});
      end
    end
    wr(4'h8, 16'h0000);
    errAt = nWords;
    errCrc = 1'b1;
    cmd(8'h00, 16'h0003, 48'h0, 8'h3B);
    words(3);
    idle;
    stat(8'h41, 8'h80);
    rd(4'hA);
    chk(rdv & 16'h0004, 16'h0004);
    errAt = 16'hFFFF;
    wr(4'h9, 16'h0001);
    rd(4'h9);
    chk(rdv, 16'h0001);
    cmd(8'h40, 16'h0004, 48'h0, 8'h3B);
    words(1);
    idle;
    stat(8'h60, 8'h01);
    rd(4'hA);
    chk(rdv & 16'h0002, 16'h0002);
    wr(4'hC, 16'h0002);
    #1 chk({15'h0, irq}, 16'h0001);
    wr(4'hB, 16'h0002);
    #1 chk({15'h0, irq}, 16'h0000);
    wr(4'hC, 16'h0000);
    cmd(8'h00, 16'h0004, 48'h0, 8'h3B);
    words(1);
    idle;
    stat(8'h41, 8'h01);
    wr(4'h9, 16'h0000);
    for (i = 0; i < 3; i = i + 1)
    begin
      cmd(8'h00, 16'h0001, 48'h0, 8'h3C - 2 * i);
      stat(8'h41, 8'h04);
    end
    cmd(8'h00, 16'h0000, 48'h0, 8'h3B);
    words(300);
    rd(4'h7);
    chk(rdv & 16'h0080, 16'h0080);
    @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    rd(4'h7);
    chk(rdv & 16'h0080, 16'h0000);
    complete_run;
  end
endmodule // testbench
